// ---- rtl/plt_cfg.svh ----
`ifndef PLT_CFG_SVH
`define PLT_CFG_SVH
`define PLT_REG_TX_PATH_CONTROL 8'h16
`define PLT_REG_TX_POWER_SETTING 8'h05
`define PLT_CTRL_RESET 8'h31
`define PLT_PWR_RESET 8'h60
`define PLT_LT_HI 7
`define PLT_LT_LO 6
`define PLT_OFFS_HI 1
`define PLT_OFFS_LO 0
`define PLT_PWR_HI 4
`define PLT_PWR_LO 0
`define PLT_CLK_MHZ 125
`define PLT_LEAD_STEP_US 2
`define PLT_LEAD_STEP_CYC (`PLT_LEAD_STEP_US * `PLT_CLK_MHZ)
`define PLT_LEAD_CYC_0 (`PLT_LEAD_STEP_CYC * 1)
`define PLT_LEAD_CYC_1 (`PLT_LEAD_STEP_CYC * 2)
`define PLT_LEAD_CYC_2 (`PLT_LEAD_STEP_CYC * 3)
`define PLT_LEAD_CYC_3 (`PLT_LEAD_STEP_CYC * 4)
`define PLT_CNT_W 11
`endif

// ---- rtl/plt_pkg.sv ----
package plt_pkg;
  typedef enum logic [1:0] {
    PLT_IDLE = 2'b00,
    PLT_LEAD = 2'b01,
    PLT_SEND = 2'b10
  } plt_state_t;

  typedef struct packed {
    logic       wr_en;
    logic       rd_en;
    logic [7:0] addr;
    logic [7:0] wdata;
  } plt_bus_t;
endpackage

// ---- rtl/plt_sync.sv ----
`timescale 1ns/10ps
`default_nettype none
module plt_sync
(
  // Clock and reset
  input  wire logic clk_sys,
  input  wire logic nrst,
  // Asynchronous level in, synchronised level out
  input  wire logic async_in,
  output var  logic sync_out
);
  typedef struct packed {
    logic s1;
    logic s2;
  } plt_sync_st_t;

  plt_sync_st_t st_ff;
  plt_sync_st_t nxt_st;

  always_comb
  begin
    nxt_st.s1 = async_in;
    nxt_st.s2 = st_ff.s1;
  end

  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      st_ff <= '0;
    end
    else
    begin
      st_ff <= nxt_st;
    end
  end

  assign sync_out = st_ff.s2;
endmodule
`default_nettype wire

// ---- rtl/plt_tx_path.sv ----
// Contract
// - A read/write control register holds lead time in bits 7:6, power offset in 1:0, 5:2 reserved.
// - The amplifier enable rises a programmed interval before the first transmitted chip.
// - Lead codes 0..3 give 2, 4, 6 or 8 us, code 0 after reset.
// - The amplifier enable can be shown on the differential front-end indicator pin pair.
// - The power offset is added to the power control word before it drives the power circuit.
`timescale 1ns/10ps
`default_nettype none
`include "plt_cfg.svh"
module plt_tx_path
(
  // Clock and reset
  input  wire logic            clk_sys,
  input  wire logic            nrst,
  // Register port
  input  wire plt_pkg::plt_bus_t reg_bus,
  output logic [7:0]           reg_rdata,
  // Transmit sequencing
  input  wire logic            tx_request,
  input  wire logic            tx_done,
  output logic                 tx_data_start,
  output logic                 amp_enable,
  output logic [5:0]           tx_power_applied,
  // Front-end indicator
  input  wire logic            frontend_ind_en_pin,
  output logic                 frontend_indicator_pos,
  output logic                 frontend_indicator_neg
);
  typedef struct packed {
    // Registers
    logic [7:0]               ctrl;
    logic [7:0]               pwr;
    logic [7:0]               rdata;
    // Sequencer
    plt_pkg::plt_state_t      state;
    logic [`PLT_CNT_W-1:0]    cnt;
    // Registered outputs
    logic                     start;
    logic                     amp;
    logic [5:0]               applied;
    logic                     ind_p;
    logic                     ind_n;
  } plt_st_t;

  plt_st_t st_ff;
  plt_st_t nxt_st;
  logic    ind_en;

  // Strap-like pin comes from outside, so synchronise it
  plt_sync u_sync
  (
    .clk_sys  (clk_sys),
    .nrst     (nrst),
    .async_in (frontend_ind_en_pin),
    .sync_out (ind_en)
  );

  always_comb
  begin
    logic [`PLT_CNT_W-1:0] lead_cyc;
    logic [1:0]            lead_code;
    logic [5:0]            pwr_word;
    logic [5:0]            offs_word;
    lead_cyc     = '0;
    lead_code    = st_ff.ctrl[`PLT_LT_HI:`PLT_LT_LO];
    pwr_word     = {1'b0, st_ff.pwr[`PLT_PWR_HI:`PLT_PWR_LO]};
    offs_word    = {4'h0, st_ff.ctrl[`PLT_OFFS_HI:`PLT_OFFS_LO]};
    nxt_st       = st_ff;
    nxt_st.start = 1'b0;

    // Reserved bits store and read back like the documented ones
    if (reg_bus.wr_en)
    begin
      unique case (reg_bus.addr)
        `PLT_REG_TX_PATH_CONTROL:
        begin
          nxt_st.ctrl = reg_bus.wdata;
        end
        `PLT_REG_TX_POWER_SETTING:
        begin
          nxt_st.pwr = reg_bus.wdata;
        end
        default:
        begin
          // Writes to unmapped addresses are dropped
          nxt_st.ctrl = st_ff.ctrl;
        end
      endcase
    end

    // Read data is registered and stands until the next read
    if (reg_bus.rd_en)
    begin
      unique case (reg_bus.addr)
        `PLT_REG_TX_PATH_CONTROL:
        begin
          nxt_st.rdata = st_ff.ctrl;
        end
        `PLT_REG_TX_POWER_SETTING:
        begin
          nxt_st.rdata = st_ff.pwr;
        end
        default:
        begin
          nxt_st.rdata = 8'h00;
        end
      endcase
    end

    // Lead of (code + 1) steps of 2 us
    unique case (lead_code)
      2'h0:
      begin
        lead_cyc = `PLT_CNT_W'(`PLT_LEAD_CYC_0);
      end
      2'h1:
      begin
        lead_cyc = `PLT_CNT_W'(`PLT_LEAD_CYC_1);
      end
      2'h2:
      begin
        lead_cyc = `PLT_CNT_W'(`PLT_LEAD_CYC_2);
      end
      2'h3:
      begin
        lead_cyc = `PLT_CNT_W'(`PLT_LEAD_CYC_3);
      end
    endcase

    unique case (st_ff.state)
      plt_pkg::PLT_IDLE:
      begin
        // Requests outside idle are ignored
        // Count loads one short: the enable edge is the first lead cycle
        if (tx_request)
        begin
          nxt_st.amp   = 1'b1;
          nxt_st.cnt   = lead_cyc - `PLT_CNT_W'(1);
          nxt_st.state = plt_pkg::PLT_LEAD;
        end
      end
      plt_pkg::PLT_LEAD:
      begin
        // Start is a one-cycle pulse after the last lead cycle
        if (st_ff.cnt == '0)
        begin
          nxt_st.start = 1'b1;
          nxt_st.state = plt_pkg::PLT_SEND;
        end
        else
        begin
          nxt_st.cnt = st_ff.cnt - `PLT_CNT_W'(1);
        end
      end
      plt_pkg::PLT_SEND:
      begin
        // An end before the start pulse is not seen, so the lead always completes
        if (tx_done)
        begin
          nxt_st.amp   = 1'b0;
          nxt_st.state = plt_pkg::PLT_IDLE;
        end
      end
      default:
      begin
        // Illegal state code falls back to idle with the amplifier off
        nxt_st.amp   = 1'b0;
        nxt_st.state = plt_pkg::PLT_IDLE;
      end
    endcase

    // Offset codes other than 1..3 are software's fault; added as written
    // Six bits hold the largest word plus offset, so the sum never wraps
    nxt_st.applied = pwr_word + offs_word;

    // Both low when disabled so the pins rest at their pull-down level
    if (ind_en)
    begin
      nxt_st.ind_p = nxt_st.amp;
      nxt_st.ind_n = ~nxt_st.amp;
    end
    else
    begin
      nxt_st.ind_p = 1'b0;
      nxt_st.ind_n = 1'b0;
    end
  end

  // Asynchronous reset loads only constants
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      st_ff.ctrl    <= `PLT_CTRL_RESET;
      st_ff.pwr     <= `PLT_PWR_RESET;
      st_ff.rdata   <= 8'h00;
      st_ff.state   <= plt_pkg::PLT_IDLE;
      st_ff.cnt     <= '0;
      st_ff.start   <= 1'b0;
      st_ff.amp     <= 1'b0;
      st_ff.applied <= 6'h00;
      st_ff.ind_p   <= 1'b0;
      st_ff.ind_n   <= 1'b0;
    end
    else
    begin
      st_ff <= nxt_st;
    end
  end

  // Every output comes straight from a flip-flop
  assign reg_rdata              = st_ff.rdata;
  assign tx_data_start          = st_ff.start;
  assign amp_enable             = st_ff.amp;
  assign tx_power_applied       = st_ff.applied;
  assign frontend_indicator_pos = st_ff.ind_p;
  assign frontend_indicator_neg = st_ff.ind_n;
endmodule
`default_nettype wire

// ---- tb/plt_frontend.sv ----
`timescale 1ns/10ps
`default_nettype none
module plt_frontend
(
  // Pin pair in
  input  wire logic frontend_indicator_pos,
  input  wire logic frontend_indicator_neg,
  // Amplifier state out
  output var  logic pa_on
);
  // Parked pins (both low) must keep the front-end off
  assign pa_on = frontend_indicator_pos & ~frontend_indicator_neg;
endmodule
`default_nettype wire

// ---- tb/plt_tx_path_sva.sv ----
`timescale 1ns/10ps
`default_nettype none
module plt_tx_path_sva
(
  // Watched
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic tx_data_start,
  input wire logic amp_enable,
  input wire logic frontend_indicator_pos,
  input wire logic frontend_indicator_neg
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  property p_lead; tx_data_start |-> $past(amp_enable, 250); endproperty
  a_lead: assert property (p_lead) else $error("lead short");
  property p_rise; $rose(amp_enable) |-> !tx_data_start; endproperty
  a_rise: assert property (p_rise) else $error("no lead");
  property p_once; tx_data_start |-> amp_enable ##1 !tx_data_start; endproperty
  a_once: assert property (p_once) else $error("start pulse");
  property p_pos; frontend_indicator_pos |-> amp_enable; endproperty
  a_pos: assert property (p_pos) else $error("pos pin");
  property p_neg; frontend_indicator_neg |-> !amp_enable; endproperty
  a_neg: assert property (p_neg) else $error("neg pin");
  c_start: cover property (tx_data_start);
  c_pos: cover property (frontend_indicator_pos);
  c_neg: cover property (frontend_indicator_neg);
endmodule
bind plt_tx_path plt_tx_path_sva u_sva (.*);
`default_nettype wire

// ---- tb/test_pa_lead_time_control.sv ----
`timescale 1ns/10ps
`default_nettype none
module test_pa_lead_time_control;
  logic clk_sys = 0, nrst = 0, tx_request = 0, tx_done = 0, frontend_ind_en_pin = 1;
  logic tx_data_start, amp_enable, frontend_indicator_pos, frontend_indicator_neg, pa_on;
  logic [7:0] reg_rdata;
  logic [5:0] tx_power_applied;
  plt_pkg::plt_bus_t reg_bus = '0;
  int n_mismatch = 0, n_compared = 0, cyc = 0;
  plt_tx_path dut (.*);
  plt_frontend fe (.*);
  initial forever #4 clk_sys = ~clk_sys;
  task test_done();
    $display("compared %0d mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  always @(posedge clk_sys)
  begin
    cyc++;
    if (cyc == 9000)
    begin
      n_mismatch++;
      test_done();
    end
  end
  task chk(string nm, logic [15:0] e, logic [15:0] g);
    n_compared++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask
  task bus(logic w, logic [7:0] a, logic [7:0] d);
    @(negedge clk_sys) reg_bus = '{w, !w, a, d};
    @(negedge clk_sys) reg_bus = '0;
  endtask
  task automatic t_lead(logic [1:0] code);
    int n = 0;
    bus(1, 8'h16, {code, 6'h32});
    tx_request = 1;
    @(negedge clk_sys) tx_request = 0;
    while (tx_data_start !== 1'b1 && n < 1200)
    begin
      @(negedge clk_sys);
      n++;
    end
    chk("lead", 16'((code + 1) * 250), 16'(n));
    chk("amp_on", 1, amp_enable);
    chk("pa_on", 1, pa_on);
    chk("ind_neg", 0, frontend_indicator_neg);
    tx_done = 1;
    @(negedge clk_sys) tx_done = 0;
    chk("amp", 0, amp_enable);
    @(negedge clk_sys);
  endtask
  task t_ind();
    frontend_ind_en_pin = 0;
    repeat (4) @(negedge clk_sys);
    chk("ind_pos", 0, frontend_indicator_pos);
    chk("ind_neg", 0, frontend_indicator_neg);
    chk("pa_off", 0, pa_on);
    frontend_ind_en_pin = 1;
    repeat (4) @(negedge clk_sys);
    chk("ind_neg", 1, frontend_indicator_neg);
  endtask
  initial
  begin
    repeat (8) @(negedge clk_sys);
    nrst = 1;
    @(negedge clk_sys);
    chk("applied", 8'h01, tx_power_applied);
    bus(0, 8'h16, 0);
    chk("ctrl", 8'h31, reg_rdata);
    bus(0, 8'h05, 0);
    chk("power", 8'h60, reg_rdata);
    bus(1, 8'h16, 8'hff);
    bus(0, 8'h16, 0);
    chk("ctrl", 8'hff, reg_rdata);
    bus(0, 8'h40, 0);
    chk("void", 0, reg_rdata);
    bus(1, 8'h05, 8'h1f);
    @(negedge clk_sys);
    chk("applied", 8'h22, tx_power_applied);
    for (int c = 0; c < 4; c++)
      t_lead(2'(c));
    t_ind();
    test_done();
  end
endmodule
`default_nettype wire
